// ---- sbi_irq_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.svh"

// Function
// - Requests split into a vector event interrupt and a data interrupt.
// - Error request ORs timing, parity, NACK, underrun and overrun errors.
// - Receive parity error counts outside data, or anywhere when broadcast.
// - Data-field underrun on transmit and overrun on broadcast receive raise errors.
// - Master raises start in address field, always on lost contention.
// - Slave raises start in address field only when addressed.
// - Slave status request raised regardless of slave transmit enable.
// - End of communication flagged when success counter reaches zero.
// - End of frame flagged when frame byte counter reaches zero.
// - Transmit write request after byte moves into shift register.
// - Receive read request only after error-free data byte.
// - Data-field NACK on transmit retransmits same byte, no data interrupt.
// - Next byte must be written before next slot, else underrun abort.
// - Frame counter preset to 20H, decremented every data acknowledge slot.
// - Success counter loads byte count, decrements on ACK only.
module sbi_irq_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire sbi_pkg::wb_req_t wbReq,
  output sbi_pkg::wb_rsp_t wbRsp,
  // Protocol engine
  input wire sbi_pkg::eng_evt_t evt,
  output sbi_pkg::eng_ctl_t engCtl,
  // Interrupts
  output logic data_transfer_irq,
  output logic bus_event_irq
);

  // ****************************************************************
  // Wishbone slave.
  // ****************************************************************
  logic ack_r;
  logic [31:0] rdData_r;
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic lane0;
  logic selCtrl;
  logic selByteCnt;
  logic selData;
  logic selStatus;
  logic selCount;
  logic wrCtrl;
  logic wrByteCnt;
  logic wrData;
  logic wrStatus;
  logic rdData;
  logic [31:0] readMux;

  assign access = wbReq.cyc && wbReq.stb && !ack_r;
  assign wrAccess = access && wbReq.we;
  assign rdAccess = access && !wbReq.we;
  assign lane0 = wbReq.sel[0];
  assign selCtrl = wbReq.adr == `SBI_OFS_CTRL;
  assign selByteCnt = wbReq.adr == `SBI_OFS_BYTECNT;
  assign selData = wbReq.adr == `SBI_OFS_DATA;
  assign selStatus = wbReq.adr == `SBI_OFS_STATUS;
  assign selCount = wbReq.adr == `SBI_OFS_COUNT;
  assign wrCtrl = wrAccess && lane0 && selCtrl;
  assign wrByteCnt = wrAccess && lane0 && selByteCnt;
  assign wrData = wrAccess && lane0 && selData;
  assign wrStatus = wrAccess && lane0 && selStatus;
  assign rdData = rdAccess && selData;

  // ****************************************************************
  // Software-visible control registers.
  // ****************************************************************
  logic [7:0] ctrl_r;
  logic [7:0] byteCnt_r;
  logic [7:0] dataBuffer_r;
  logic [7:0] rxBuffer_r;
  logic txFull_r;
  logic rxFull_r;
  logic retry_r;
  logic overrun_r;
  logic flagReset;

  // Arming a new request starts from clean end flags.
  assign flagReset = wrCtrl && (wbReq.dat[`SBI_CTRL_MREQ] ||
                     wbReq.dat[`SBI_CTRL_STX] || wbReq.dat[`SBI_CTRL_SRX]);

  // ****************************************************************
  // Communication state.
  // ****************************************************************
  sbi_pkg::comm_state_t state_r;
  sbi_pkg::comm_state_t state_nxt;
  logic active;
  logic inData;
  logic txData;
  logic rxData;

  assign active = state_r == sbi_pkg::CS_ACTIVE;
  assign inData = evt.field == sbi_pkg::FLD_DATA;
  assign txData = active && inData && evt.isTransmitter;
  assign rxData = active && inData && !evt.isTransmitter;

  // ****************************************************************
  // Error sources.
  // ****************************************************************
  logic errTiming;
  logic errParity;
  logic errNack;
  logic errUnderrun;
  logic errOverrun;
  logic anyErr;

  assign errTiming = active && evt.timingErr;
  assign errParity = active && evt.parityErr && !evt.isTransmitter &&
                     (evt.broadcast || !inData);
  assign errNack = active && evt.ackSlot && evt.ackNack &&
                   evt.isTransmitter && !inData;
  // A slot that is a retransmission reuses the shift register.
  assign errUnderrun = txData && evt.nextSlot && !txFull_r &&
                       !retry_r;
  // Individual reception answers a late read with NACK instead.
  assign errOverrun = rxData && evt.rxByteDone && rxFull_r &&
                      evt.broadcast;
  assign anyErr = errTiming || errParity || errNack || errUnderrun ||
                  errOverrun;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sbi_pkg::CS_IDLE: begin
        if (evt.frameStart && ctrl_r[`SBI_CTRL_COMM]) begin
          state_nxt = sbi_pkg::CS_ACTIVE;
        end
      end
      sbi_pkg::CS_ACTIVE: begin
        if (anyErr) begin
          state_nxt = sbi_pkg::CS_HALT;
        end else if (evt.frameStart && !ctrl_r[`SBI_CTRL_COMM]) begin
          state_nxt = sbi_pkg::CS_IDLE;
        end
      end
      sbi_pkg::CS_HALT: begin
        // Only the next frame may wake the unit again.
        if (evt.frameStart) begin
          state_nxt = ctrl_r[`SBI_CTRL_COMM] ? sbi_pkg::CS_ACTIVE :
                      sbi_pkg::CS_IDLE;
        end
      end
      default: begin
        state_nxt = sbi_pkg::CS_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Byte counters.
  // ****************************************************************
  logic dataAck;
  logic dataGoodAck;
  logic [8:0] successCnt;
  logic [8:0] frameCnt;
  logic successZero;
  logic frameZero;
  logic [8:0] successPreset;

  assign dataAck = active && inData && evt.ackSlot;
  assign dataGoodAck = dataAck && !evt.ackNack;
  // A count of zero stands for 256 bytes in the 9-bit counter.
  assign successPreset = {byteCnt_r == 8'h00, byteCnt_r};

  sbi_down_counter successCounter (
    .clk(clk),
    .nrst(nrst),
    .load(evt.frameStart),
    .loadValue(successPreset),
    .dec(dataGoodAck),
    .count(successCnt),
    .hitZero(successZero)
  );

  sbi_down_counter frameCounter (
    .clk(clk),
    .nrst(nrst),
    .load(evt.frameStart),
    .loadValue(`SBI_FRAME_PRESET),
    .dec(dataAck),
    .count(frameCnt),
    .hitZero(frameZero)
  );

  // ****************************************************************
  // Event and data interrupt sources.
  // ****************************************************************
  logic evStart;
  logic evStatus;
  logic evEndTrans;
  logic evEndFrame;
  logic txIrq;
  logic rxIrq;
  logic rxStore;
  logic nackRetry;
  logic [`SBI_NUM_FLAGS-1:0] flagSet;

  assign evStart = active && ((evt.addrFieldDone &&
                   (evt.isMaster || evt.addressedSlave)) ||
                   (evt.isMaster && evt.lostContention));
  // The engine ignores the request when slave transmit is disabled.
  assign evStatus = active && evt.ctrlFieldDone && !evt.isMaster &&
                    evt.addressedSlave && evt.statusRequest;
  assign evEndTrans = successZero && !anyErr;
  assign evEndFrame = frameZero && !anyErr;
  assign nackRetry = txData && evt.ackSlot && evt.ackNack;
  assign txIrq = txData && evt.shiftLoaded && !retry_r;
  assign rxStore = rxData && evt.rxByteDone && !evt.parityErr &&
                   !rxFull_r && !anyErr;
  assign rxIrq = rxStore;
  assign flagSet = {evEndFrame, evEndTrans, evStatus, evStart, anyErr};

  // ****************************************************************
  // Sticky status flags, write one to clear, set wins.
  // ****************************************************************
  logic [`SBI_NUM_FLAGS-1:0] flag_r;
  logic [4:0] errSrc_r;

  genvar gi;
  generate
    for (gi = 0; gi < `SBI_NUM_FLAGS; gi = gi + 1) begin : g_flag
      logic clr;
      assign clr = (wrStatus && wbReq.dat[gi]) ||
                   (flagReset && gi >= `SBI_ST_ENDTRANS);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          flag_r[gi] <= 1'b0;
        end else if (flagSet[gi]) begin
          flag_r[gi] <= 1'b1;
        end else if (clr) begin
          flag_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      errSrc_r <= 5'h00;
    end else if (anyErr) begin
      errSrc_r <= {errOverrun, errUnderrun, errNack, errParity, errTiming};
    end
  end

  // ****************************************************************
  // Register and buffer updates.
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `SBI_CTRL_RST;
      byteCnt_r <= `SBI_BYTECNT_RST;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= wbReq.dat[7:0];
      end
      if (wrByteCnt) begin
        byteCnt_r <= wbReq.dat[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataBuffer_r <= 8'h00;
      txFull_r <= 1'b0;
    end else begin
      if (wrData) begin
        dataBuffer_r <= wbReq.dat[7:0];
      end
      if (wrData) begin
        txFull_r <= 1'b1;
      end else if (txIrq) begin
        txFull_r <= 1'b0;
      end
    end
  end

  // The shift register keeps the byte, so a retry must not ask again.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      retry_r <= 1'b0;
    end else if (nackRetry) begin
      retry_r <= 1'b1;
    end else if ((txData && evt.shiftLoaded) || !active) begin
      retry_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxBuffer_r <= 8'h00;
      rxFull_r <= 1'b0;
    end else begin
      if (rxStore) begin
        rxBuffer_r <= evt.rxByte;
      end
      if (rxStore) begin
        rxFull_r <= 1'b1;
      end else if (rdData) begin
        rxFull_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overrun_r <= 1'b0;
    end else if (errOverrun) begin
      overrun_r <= 1'b1;
    end else if (rdData) begin
      overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= sbi_pkg::CS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Interrupt pulses.
  // ****************************************************************
  logic dataIrq_r;
  logic busIrq_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataIrq_r <= 1'b0;
      busIrq_r <= 1'b0;
    end else begin
      dataIrq_r <= txIrq || rxIrq;
      busIrq_r <= |flagSet;
    end
  end

  assign data_transfer_irq = dataIrq_r;
  assign bus_event_irq = busIrq_r;

  // ****************************************************************
  // Engine controls.
  // ****************************************************************
  always_comb begin
    engCtl.commEnable = ctrl_r[`SBI_CTRL_COMM];
    engCtl.masterReq = ctrl_r[`SBI_CTRL_MREQ];
    engCtl.slaveRxEnable = ctrl_r[`SBI_CTRL_SRX];
    engCtl.slaveTxEnable = ctrl_r[`SBI_CTRL_STX];
    engCtl.abort = anyErr;
    engCtl.retransmit = nackRetry;
    engCtl.rxNack = rxFull_r;
    engCtl.txByte = dataBuffer_r;
  end

  // ****************************************************************
  // Read mux and bus answer.
  // ****************************************************************
  always_comb begin
    readMux = 32'h0000_0000;
    if (selCtrl) begin
      readMux[7:0] = ctrl_r;
    end else if (selByteCnt) begin
      readMux[7:0] = byteCnt_r;
    end else if (selData) begin
      readMux[7:0] = rxBuffer_r;
    end else if (selStatus) begin
      readMux[`SBI_NUM_FLAGS-1:0] = flag_r;
      readMux[`SBI_ST_TXEMPTY] = !txFull_r;
      readMux[`SBI_ST_RXFULL] = rxFull_r;
      readMux[10] = overrun_r;
      readMux[`SBI_ST_ESRC_LSB+4:`SBI_ST_ESRC_LSB] = errSrc_r;
    end else if (selCount) begin
      readMux[8:0] = successCnt;
      readMux[24:16] = frameCnt;
    end
  end

  // Unmapped words still answer, reading zero and ignoring writes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rdData_r <= 32'h0000_0000;
    end else begin
      ack_r <= access;
      if (rdAccess) begin
        rdData_r <= readMux;
      end
    end
  end

  assign wbRsp.ack = ack_r;
  assign wbRsp.dat = rdData_r;

endmodule
`default_nettype wire

// ---- sbi_regs.svh ----
`ifndef SBI_REGS_SVH
`define SBI_REGS_SVH

// ****************************************************************
// Register byte offsets on the Wishbone slave.
// ****************************************************************
`define SBI_OFS_CTRL 5'h00
`define SBI_OFS_BYTECNT 5'h04
`define SBI_OFS_DATA 5'h08
`define SBI_OFS_STATUS 5'h0c
`define SBI_OFS_COUNT 5'h10

// ****************************************************************
// Field positions.
// ****************************************************************
`define SBI_CTRL_COMM 0
`define SBI_CTRL_MREQ 1
`define SBI_CTRL_SRX 2
`define SBI_CTRL_STX 4
`define SBI_ST_ERR 0
`define SBI_ST_START 1
`define SBI_ST_STATUS 2
`define SBI_ST_ENDTRANS 3
`define SBI_ST_ENDFRAME 4
`define SBI_NUM_FLAGS 5
`define SBI_ST_TXEMPTY 8
`define SBI_ST_RXFULL 9
`define SBI_ST_ESRC_LSB 16

// ****************************************************************
// Reset and preset values.
// ****************************************************************
`define SBI_CTRL_RST 8'h00
`define SBI_BYTECNT_RST 8'h01
`define SBI_FRAME_PRESET 9'h020
`define SBI_CNT_ZERO 9'h000
`define SBI_CNT_ONE 9'h001

`endif

// ---- sbi_pkg.sv ----
package sbi_pkg;

  // Field of the frame that the protocol engine is working on.
  typedef enum logic [4:0] {
    FLD_IDLE = 5'b00001,
    FLD_ADDR = 5'b00010,
    FLD_CTRL = 5'b00100,
    FLD_LEN = 5'b01000,
    FLD_DATA = 5'b10000
  } field_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_ACTIVE = 3'b010,
    CS_HALT = 3'b100
  } comm_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Event strobes, one cycle each, and held qualifiers from the bit-level protocol engine.
  typedef struct packed {
    logic frameStart;
    logic broadcast;
    logic isMaster;
    logic isTransmitter;
    logic lostContention;
    logic addrFieldDone;
    logic addressedSlave;
    logic ctrlFieldDone;
    logic statusRequest;
    logic timingErr;
    logic parityErr;
    logic ackSlot;
    logic ackNack;
    logic shiftLoaded;
    logic rxByteDone;
    logic nextSlot;
    logic [7:0] rxByte;
    field_t field;
  } eng_evt_t;

  // Controls handed to the protocol engine.
  typedef struct packed {
    logic commEnable;
    logic masterReq;
    logic slaveRxEnable;
    logic slaveTxEnable;
    logic abort;
    logic retransmit;
    logic rxNack;
    logic [7:0] txByte;
  } eng_ctl_t;

endpackage

// ---- sbi_down_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.svh"

module sbi_down_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic load,
  input wire logic [8:0] loadValue,
  input wire logic dec,
  // Result
  output logic [8:0] count,
  output logic hitZero
);

  logic [8:0] count_r;
  logic [8:0] count_nxt;
  logic canDec;

  // Holding at zero keeps a late slot from wrapping to 511.
  assign canDec = dec && (count_r != `SBI_CNT_ZERO);
  assign count_nxt = load ? loadValue :
                     canDec ? count_r - `SBI_CNT_ONE : count_r;
  assign hitZero = canDec && (count_r == `SBI_CNT_ONE);
  assign count = count_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= `SBI_CNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- sbi_irq_ctrl_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ******************************************************************
// Port checker for the interrupt controller.
// ******************************************************************
module sbi_irq_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone
  input wire sbi_pkg::wb_req_t wbReq,
  input wire sbi_pkg::wb_rsp_t wbRsp,
  // Engine
  input wire sbi_pkg::eng_evt_t evt,
  input wire sbi_pkg::eng_ctl_t engCtl,
  // Interrupts
  input wire logic data_transfer_irq,
  input wire logic bus_event_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_data_pulse: assert property (data_transfer_irq |=> !data_transfer_irq)
    else $error("data interrupt longer than one cycle");
  a_event_pulse: assert property (bus_event_irq |=> !bus_event_irq)
    else $error("event interrupt longer than one cycle");
  a_ack_answer: assert property
    (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("bus access not answered in one cycle");
  a_abort_irq: assert property (engCtl.abort |=> bus_event_irq)
    else $error("abort without event interrupt");
  a_abort_cause: assert property (engCtl.abort |-> evt.timingErr ||
    evt.parityErr || evt.ackSlot || evt.nextSlot || evt.rxByteDone)
    else $error("abort without an error source");
  a_retx_cause: assert property (engCtl.retransmit |-> evt.ackSlot &&
    evt.ackNack && evt.isTransmitter && evt.field == sbi_pkg::FLD_DATA)
    else $error("retransmit without data field nack");
  a_data_cause: assert property (data_transfer_irq |->
    $past(evt.shiftLoaded || evt.rxByteDone))
    else $error("data interrupt without byte event");
  a_halt_quiet: assert property (engCtl.abort ##1 !evt.frameStart
    |=> !data_transfer_irq && !bus_event_irq)
    else $error("interrupt after error in same frame");
  a_slave_start: assert property (evt.addrFieldDone && !evt.isMaster &&
    !evt.addressedSlave && !evt.lostContention && !engCtl.abort
    |=> !bus_event_irq)
    else $error("start raised for unaddressed slave");
  a_rx_err_quiet: assert property (evt.rxByteDone && engCtl.abort
    |=> !data_transfer_irq)
    else $error("read request for faulty byte");
endmodule

bind sbi_irq_ctrl sbi_irq_ctrl_props chk (
  .clk(clk), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp), .evt(evt),
  .engCtl(engCtl), .data_transfer_irq(data_transfer_irq),
  .bus_event_irq(bus_event_irq)
);
`default_nettype wire

// ---- sbi_engine_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ******************************************************************
// Protocol engine model: drives one event cycle, then lets it lapse.
// ******************************************************************
module sbi_engine_model (
  // Clock
  input wire logic clk,
  // Event strobes
  output var sbi_pkg::eng_evt_t evt
);
  // Strobe bits of the event word, cleared after their single cycle.
  localparam logic [28:0] PULSES = 29'h11aee000;
  // Byte and nack qualifiers are inverted once they lapse, so the
  // controller cannot lean on a stale value.
  localparam logic [28:0] LAPSED = 29'h00011fe0;
  initial begin
    evt = '0;
    evt.field = sbi_pkg::FLD_IDLE;
  end
  task automatic send(input sbi_pkg::eng_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= sbi_pkg::eng_evt_t'((e & ~PULSES) ^ LAPSED);
  endtask
endmodule
`default_nettype wire

// ---- sbi_irq_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.svh"
// ******************************************************************
// Bench: host over Wishbone, engine model on the event side.
// ******************************************************************
module sbi_irq_ctrl_tb;
  localparam int FS = 0, LC = 1, AD = 2, CD = 3, TE = 4;
  localparam int PE = 5, AK = 6, SL = 7, RX = 8, NS = 9;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  sbi_pkg::wb_req_t wbReq = '0;
  sbi_pkg::wb_rsp_t wbRsp;
  sbi_pkg::eng_evt_t evt;
  sbi_pkg::eng_evt_t lv;
  sbi_pkg::eng_ctl_t engCtl;
  logic dataIrq;
  logic eventIrq;
  logic [31:0] rdv;
  int miscompares = 0;
  int compares = 0;
  int i;
  always #25 clk = ~clk;
  sbi_irq_ctrl uut (.clk(clk), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp),
    .evt(evt), .engCtl(engCtl), .data_transfer_irq(dataIrq),
    .bus_event_irq(eventIrq));
  sbi_engine_model eng (.clk(clk), .evt(evt));

  task report_and_stop;
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    @(posedge clk);
    while (wbRsp.ack !== 1'b1) @(posedge clk);
    rdv = wbRsp.dat;
    wbReq <= '0;
  endtask
  task rc(input string n, input logic [4:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(n, rdv & m, exp);
  endtask
  // One engine event; both interrupts are judged one cycle later.
  task ev(input int k, input logic d, input logic b);
    sbi_pkg::eng_evt_t t;
    t = lv;
    case (k)
      FS: t.frameStart = 1'b1;
      LC: t.lostContention = 1'b1;
      AD: t.addrFieldDone = 1'b1;
      CD: t.ctrlFieldDone = 1'b1;
      TE: t.timingErr = 1'b1;
      PE: t.parityErr = 1'b1;
      AK: t.ackSlot = 1'b1;
      SL: t.shiftLoaded = 1'b1;
      RX: t.rxByteDone = 1'b1;
      default: t.nextSlot = 1'b1;
    endcase
    eng.send(t);
    #1;
    chk("dataIrq", dataIrq, d);
    chk("eventIrq", eventIrq, b);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end

  initial begin
    lv = '0;
    lv.field = sbi_pkg::FLD_IDLE;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rc("bytecnt", `SBI_OFS_BYTECNT, 32'hff, 32'h01);
    rc("unmapped", 5'h14, 32'hffffffff, 32'h0);
    wb(1'b1, `SBI_OFS_BYTECNT, 32'h02);
    wb(1'b1, `SBI_OFS_DATA, 32'ha5);
    wb(1'b1, `SBI_OFS_CTRL, 32'h07);
    chk("ctl", {engCtl.commEnable, engCtl.masterReq, engCtl.slaveRxEnable,
      engCtl.slaveTxEnable}, 4'he);
    chk("txByte", engCtl.txByte, 8'ha5);
    lv.isMaster = 1'b1;
    lv.isTransmitter = 1'b1;
    ev(FS, 1'b0, 1'b0);
    lv.field = sbi_pkg::FLD_ADDR;
    ev(AD, 1'b0, 1'b1);
    lv.field = sbi_pkg::FLD_DATA;
    ev(SL, 1'b1, 1'b0);
    rc("status", `SBI_OFS_STATUS, 32'h102, 32'h102);
    ev(NS, 1'b0, 1'b1);
    rc("errsrc", `SBI_OFS_STATUS, 32'h1f0001, 32'h080001);
    ev(SL, 1'b0, 1'b0);
    // The aborted byte is resent in the next frame.
    wb(1'b1, `SBI_OFS_STATUS, 32'h1f);
    wb(1'b1, `SBI_OFS_DATA, 32'ha5);
    ev(FS, 1'b0, 1'b0);
    ev(SL, 1'b1, 1'b0);
    wb(1'b1, `SBI_OFS_DATA, 32'h5a);
    ev(AK, 1'b0, 1'b0);
    lv.ackNack = 1'b1;
    ev(AK, 1'b0, 1'b0);
    lv.ackNack = 1'b0;
    ev(SL, 1'b0, 1'b0);
    ev(AK, 1'b0, 1'b1);
    rc("count", `SBI_OFS_COUNT, 32'h01ff01ff, 32'h001d0000);
    rc("endcomm", `SBI_OFS_STATUS, 32'h1f, 32'h08);
    wb(1'b1, `SBI_OFS_STATUS, 32'h1f);
    wb(1'b1, `SBI_OFS_BYTECNT, 32'h00);
    ev(FS, 1'b0, 1'b0);
    for (i = 0; i < 31; i++) ev(AK, 1'b0, 1'b0);
    ev(AK, 1'b0, 1'b1);
    rc("count", `SBI_OFS_COUNT, 32'h01ff01ff, 32'h000000e0);
    rc("endframe", `SBI_OFS_STATUS, 32'h1f, 32'h10);
    wb(1'b1, `SBI_OFS_CTRL, 32'h05);
    lv.isMaster = 1'b0;
    lv.isTransmitter = 1'b0;
    ev(FS, 1'b0, 1'b0);
    lv.field = sbi_pkg::FLD_ADDR;
    ev(AD, 1'b0, 1'b0);
    lv.addressedSlave = 1'b1;
    ev(AD, 1'b0, 1'b1);
    lv.field = sbi_pkg::FLD_CTRL;
    lv.statusRequest = 1'b1;
    ev(CD, 1'b0, 1'b1);
    rc("status", `SBI_OFS_STATUS, 32'h1f, 32'h06);
    wb(1'b1, `SBI_OFS_CTRL, 32'h15);
    chk("slaveTx", engCtl.slaveTxEnable, 1'b1);
    lv.statusRequest = 1'b0;
    lv.field = sbi_pkg::FLD_DATA;
    lv.rxByte = 8'h3c;
    ev(RX, 1'b1, 1'b0);
    rc("rxData", `SBI_OFS_DATA, 32'hff, 32'h3c);
    ev(PE, 1'b0, 1'b0);
    lv.field = sbi_pkg::FLD_CTRL;
    ev(PE, 1'b0, 1'b1);
    rc("errsrc", `SBI_OFS_STATUS, 32'h1f0001, 32'h020001);
    wb(1'b1, `SBI_OFS_STATUS, 32'h1f);
    lv.broadcast = 1'b1;
    lv.field = sbi_pkg::FLD_DATA;
    ev(FS, 1'b0, 1'b0);
    ev(RX, 1'b1, 1'b0);
    lv.rxByte = 8'hc3;
    ev(RX, 1'b0, 1'b1);
    chk("rxNack", engCtl.rxNack, 1'b1);
    rc("errsrc", `SBI_OFS_STATUS, 32'h1f0601, 32'h100601);
    rc("rxData", `SBI_OFS_DATA, 32'hff, 32'h3c);
    chk("rxNack", engCtl.rxNack, 1'b0);
    ev(FS, 1'b0, 1'b0);
    ev(PE, 1'b0, 1'b1);
    lv.broadcast = 1'b0;
    lv.isMaster = 1'b1;
    wb(1'b1, `SBI_OFS_CTRL, 32'h03);
    ev(FS, 1'b0, 1'b0);
    lv.field = sbi_pkg::FLD_LEN;
    ev(TE, 1'b0, 1'b1);
    ev(FS, 1'b0, 1'b0);
    lv.field = sbi_pkg::FLD_ADDR;
    ev(LC, 1'b0, 1'b1);
    report_and_stop;
  end
endmodule
`default_nettype wire
